// File: mcu_exec_map.svh
`ifndef MCU_EXEC_MAP_SVH
`define MCU_EXEC_MAP_SVH

// Data widths and reset values
`define EXEC_DATA_W        8
`define EXEC_PC_W          11
`define EXEC_ADDR_W        7
`define EXEC_ACC_RST       8'h00
`define EXEC_CARRY_RST     1'b0
`define EXEC_GIE_RST       1'b0
`define EXEC_ALL_ONES      8'hff
`define EXEC_PC_STEP       11'h001
// Machine cycles for the two-cycle forms
`define EXEC_RET_CYCLES    2
`define EXEC_SKIP_CYCLES   2

`endif

// File: mcu_exec_pkg.sv
`default_nettype none
package mcu_exec_pkg;

    // Operations carried out by the execute stage
    typedef enum logic [4:0] {
        OP_NO_OPERATION,
        OP_COPY_MEM_TO_WORK,
        OP_COPY_IMM_TO_WORK,
        OP_COPY_WORK_TO_MEM,
        OP_OR_MEM,
        OP_OR_IMM,
        OP_OR_INTO_MEMORY,
        OP_SUBROUTINE_EXIT,
        OP_RETURN_WITH_VALUE,
        OP_INTERRUPT_EXIT,
        OP_ROTATE_LEFT,
        OP_ROTATE_LEFT_TO_WORK,
        OP_ROTATE_LEFT_VIA_CARRY,
        OP_ROTATE_LEFT_VIA_CARRY_TO_WORK,
        OP_ROTATE_RIGHT,
        OP_ROTATE_RIGHT_TO_WORK,
        OP_ROTATE_RIGHT_VIA_CARRY,
        OP_ROTATE_RIGHT_VIA_CARRY_TO_WORK,
        OP_SUBTRACT_WITH_BORROW,
        OP_SUBTRACT_BORROW_TO_MEM,
        OP_DECREMENT_SKIP_ZERO,
        OP_DECREMENT_TO_WORK_SKIP_ZERO,
        OP_BYTE_SET,
        OP_BIT_SET,
        OP_INCREMENT_SKIP_ZERO
    } exec_op_type;

    // Execute stage sequencing
    typedef enum logic [0:0] {
        ST_RUN,
        ST_EXTRA
    } exec_state_type;

endpackage : mcu_exec_pkg
`default_nettype wire

// File: mcu_instruction_execute.sv
// How it works
// RULE1: copy from memory loads the byte into the accumulator, memory kept.
// RULE2: copy immediate loads the 8-bit constant into the accumulator.
// RULE3: store form writes the accumulator into memory, accumulator kept.
// RULE4: no_operation changes nothing and advances the program counter by one.
// RULE5: OR forms combine accumulator with memory or immediate.
// RULE6: subroutine_exit pops the program counter and takes two cycles.
// RULE7: return-with-value pops the program counter and loads the immediate.
// RULE8: interrupt_exit pops the program counter and sets the global enable.
// RULE9: rotate_left rotates memory left in place, bit 7 into bit 0.
// RULE10: rotate left to work puts rotated memory in accumulator only.
// RULE11: left rotation via carry over nine bits, result to memory.
// RULE12: same nine-bit left rotation, result to accumulator, memory kept.
// RULE13: rotate_right rotates memory right in place, bit 0 into bit 7.
// RULE14: rotate right to work puts rotated memory in accumulator only.
// RULE15: right rotation via carry over nine bits, result to memory.
// RULE16: same nine-bit right rotation, result to accumulator, memory kept.
// RULE17: subtract_with_borrow: accumulator plus inverted byte plus carry.
// RULE18: memory variant writes that same sum back into memory.
// RULE19: decrement_skip_zero writes memory minus one, skips on zero result.
// RULE20: decrement to work loads memory minus one, skips on zero result.
// RULE21: byte set writes all ones into memory.
// RULE22: bit set forces the selected bit to one, others kept.
// RULE23: increment_skip_zero writes memory plus one, skips on zero result.
// RULE24: other forms take one cycle; increments and decrements wrap.
`include "mcu_exec_map.svh"
`default_nettype none
module mcu_instruction_execute
    import mcu_exec_pkg::*;
#(
    parameter int DATA_W = `EXEC_DATA_W,
    parameter int PC_W   = `EXEC_PC_W,
    parameter int ADDR_W = `EXEC_ADDR_W
) (
    input  wire logic              clk_i,
    input  wire logic              rstn_i,
    input  wire logic              issue_valid_i,
    output logic                   issue_ready_o,
    input  wire exec_op_type       issue_op_i,
    input  wire logic [ADDR_W-1:0] issue_addr_i,
    input  wire logic [DATA_W-1:0] issue_imm_i,
    input  wire logic [2:0]        issue_bit_i,
    input  wire logic [PC_W-1:0]   issue_pc_i,
    input  wire logic [DATA_W-1:0] mem_rdata_i,
    input  wire logic [PC_W-1:0]   stack_top_i,
    output logic                   mem_we_o,
    output logic [ADDR_W-1:0]      mem_addr_o,
    output logic [DATA_W-1:0]      mem_wdata_o,
    output logic                   stack_pop_o,
    output logic                   pc_load_o,
    output logic [PC_W-1:0]        pc_o,
    output logic                   discard_o,
    output logic                   done_o,
    output logic [DATA_W-1:0]      acc_o,
    output logic                   carry_o,
    output logic                   global_interrupt_enable_o
);

    // Rotate helpers shared by the in-place and to-work forms
    function automatic logic [DATA_W-1:0] rot_left(
        input logic [DATA_W-1:0] v,
        input logic              fill
    );
        rot_left = {v[DATA_W-2:0], fill};
    endfunction : rot_left

    function automatic logic [DATA_W-1:0] rot_right(
        input logic [DATA_W-1:0] v,
        input logic              fill
    );
        rot_right = {fill, v[DATA_W-1:1]};
    endfunction : rot_right

    logic [DATA_W-1:0] acc_r;
    logic              carry_r;
    logic              gie_r;
    exec_state_type    state_r;
    logic              accept;
    logic [DATA_W-1:0] m;
    logic [DATA_W-1:0] inc_v;
    logic [DATA_W-1:0] dec_v;
    logic [DATA_W-1:0] diff_v;
    logic [DATA_W-1:0] res;
    logic              wr_acc;
    logic              wr_mem;
    logic              wr_carry;
    logic              new_carry;
    logic              pop;
    logic              two_cycle;

    assign m      = mem_rdata_i;
    assign accept = issue_valid_i && (state_r == ST_RUN);
    assign issue_ready_o = (state_r == ST_RUN);
    // RULE24: wrap modulo 256
    assign inc_v = m + {{(DATA_W-1){1'b0}}, 1'b1};
    assign dec_v = m - {{(DATA_W-1){1'b0}}, 1'b1};
    // RULE17: inverted operand plus carry
    assign diff_v = acc_r + ~m + {{(DATA_W-1){1'b0}}, carry_r};

    // Operation decode: result, destination and cycle count
    always_comb begin
        res       = acc_r;
        wr_acc    = 1'b0;
        wr_mem    = 1'b0;
        wr_carry  = 1'b0;
        new_carry = carry_r;
        pop       = 1'b0;
        two_cycle = 1'b0;
        case (issue_op_i)
            // RULE4: nothing written
            OP_NO_OPERATION: begin
                res = acc_r;
            end
            // RULE1: memory to accumulator
            OP_COPY_MEM_TO_WORK: begin
                res    = m;
                wr_acc = 1'b1;
            end
            // RULE2: immediate to accumulator
            OP_COPY_IMM_TO_WORK: begin
                res    = issue_imm_i;
                wr_acc = 1'b1;
            end
            // RULE3: accumulator to memory
            OP_COPY_WORK_TO_MEM: begin
                res    = acc_r;
                wr_mem = 1'b1;
            end
            // RULE5: OR forms
            OP_OR_MEM: begin
                res    = acc_r | m;
                wr_acc = 1'b1;
            end
            OP_OR_IMM: begin
                res    = acc_r | issue_imm_i;
                wr_acc = 1'b1;
            end
            OP_OR_INTO_MEMORY: begin
                res    = acc_r | m;
                wr_mem = 1'b1;
            end
            // RULE6: pop with extra cycle
            OP_SUBROUTINE_EXIT: begin
                pop       = 1'b1;
                two_cycle = 1'b1;
            end
            // RULE7: pop and load immediate
            OP_RETURN_WITH_VALUE: begin
                pop    = 1'b1;
                res    = issue_imm_i;
                wr_acc = 1'b1;
            end
            // RULE8: pop, enable set below
            OP_INTERRUPT_EXIT: begin
                pop = 1'b1;
            end
            // RULE9: rotate memory left
            OP_ROTATE_LEFT: begin
                res    = rot_left(m, m[DATA_W-1]);
                wr_mem = 1'b1;
            end
            // RULE10: rotate left into accumulator
            OP_ROTATE_LEFT_TO_WORK: begin
                res    = rot_left(m, m[DATA_W-1]);
                wr_acc = 1'b1;
            end
            // RULE11: nine-bit left to memory
            OP_ROTATE_LEFT_VIA_CARRY: begin
                res       = rot_left(m, carry_r);
                wr_mem    = 1'b1;
                wr_carry  = 1'b1;
                new_carry = m[DATA_W-1];
            end
            // RULE12: nine-bit left to accumulator
            OP_ROTATE_LEFT_VIA_CARRY_TO_WORK: begin
                res       = rot_left(m, carry_r);
                wr_acc    = 1'b1;
                wr_carry  = 1'b1;
                new_carry = m[DATA_W-1];
            end
            // RULE13: rotate memory right
            OP_ROTATE_RIGHT: begin
                res    = rot_right(m, m[0]);
                wr_mem = 1'b1;
            end
            // RULE14: rotate right into accumulator
            OP_ROTATE_RIGHT_TO_WORK: begin
                res    = rot_right(m, m[0]);
                wr_acc = 1'b1;
            end
            // RULE15: nine-bit right to memory
            OP_ROTATE_RIGHT_VIA_CARRY: begin
                res       = rot_right(m, carry_r);
                wr_mem    = 1'b1;
                wr_carry  = 1'b1;
                new_carry = m[0];
            end
            // RULE16: nine-bit right to accumulator
            OP_ROTATE_RIGHT_VIA_CARRY_TO_WORK: begin
                res       = rot_right(m, carry_r);
                wr_acc    = 1'b1;
                wr_carry  = 1'b1;
                new_carry = m[0];
            end
            // RULE17: difference to accumulator
            OP_SUBTRACT_WITH_BORROW: begin
                res    = diff_v;
                wr_acc = 1'b1;
            end
            // RULE18: difference to memory
            OP_SUBTRACT_BORROW_TO_MEM: begin
                res    = diff_v;
                wr_mem = 1'b1;
            end
            // RULE19: decrement in place, skip on zero
            OP_DECREMENT_SKIP_ZERO: begin
                res       = dec_v;
                wr_mem    = 1'b1;
                two_cycle = (dec_v == '0);
            end
            // RULE20: decrement to accumulator, skip on zero
            OP_DECREMENT_TO_WORK_SKIP_ZERO: begin
                res       = dec_v;
                wr_acc    = 1'b1;
                two_cycle = (dec_v == '0);
            end
            // RULE21: all ones
            OP_BYTE_SET: begin
                res    = `EXEC_ALL_ONES;
                wr_mem = 1'b1;
            end
            // RULE22: single bit forced high
            OP_BIT_SET: begin
                res    = m | (DATA_W'(1) << issue_bit_i);
                wr_mem = 1'b1;
            end
            // RULE23: increment in place, skip on zero
            OP_INCREMENT_SKIP_ZERO: begin
                res       = inc_v;
                wr_mem    = 1'b1;
                two_cycle = (inc_v == '0);
            end
            default: begin
                res = acc_r;
            end
        endcase
    end

    // Memory write port, combinational handshake with the data memory
    assign mem_addr_o  = issue_addr_i;
    assign mem_wdata_o = res;
    assign mem_we_o    = accept && wr_mem;
    assign stack_pop_o = accept && pop;

    // Accumulator
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            acc_r <= `EXEC_ACC_RST;
        end else if (accept && wr_acc) begin
            acc_r <= res;
        end
    end

    // Carry flag
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            carry_r <= `EXEC_CARRY_RST;
        end else if (accept && wr_carry) begin
            carry_r <= new_carry;
        end
    end

    // Global interrupt enable
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            gie_r <= `EXEC_GIE_RST;
        end else if (accept && issue_op_i == OP_INTERRUPT_EXIT) begin
            // RULE8: enable set on return
            gie_r <= 1'b1;
        end
    end

    // Sequencing: second cycle for subroutine_exit and taken skips
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state_r <= ST_RUN;
        end else begin
            case (state_r)
                ST_RUN: begin
                    // RULE24: single cycle unless flagged
                    if (accept && two_cycle) begin
                        state_r <= ST_EXTRA;
                    end
                end
                ST_EXTRA: begin
                    state_r <= ST_RUN;
                end
                default: begin
                    state_r <= ST_RUN;
                end
            endcase
        end
    end

    // Program counter load strobe and next value
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pc_load_o <= 1'b0;
            pc_o      <= '0;
        end else begin
            pc_load_o <= accept;
            if (accept && pop) begin
                // RULE6: pop into program counter
                pc_o <= stack_top_i;
            end else if (accept) begin
                // RULE4: step by one
                pc_o <= issue_pc_i + `EXEC_PC_STEP;
            end
        end
    end

    // Discard strobe for a taken skip; returns refetch on their own
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            discard_o <= 1'b0;
        end else begin
            // RULE19: prefetched word dropped
            discard_o <= accept && two_cycle && !pop;
        end
    end

    // Completion strobe, held back by the extra cycle where one is needed
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            done_o <= 1'b0;
        end else begin
            done_o <= (accept && !two_cycle) || (state_r == ST_EXTRA);
        end
    end

    assign acc_o                     = acc_r;
    assign carry_o                   = carry_r;
    assign global_interrupt_enable_o = gie_r;

endmodule : mcu_instruction_execute
`default_nettype wire

// File: mcu_instruction_execute_props.sv
`default_nettype none
module mcu_instruction_execute_props
    import mcu_exec_pkg::*;
#(
    parameter int DATA_W = 8,
    parameter int PC_W   = 11,
    parameter int ADDR_W = 7
) (
    input wire logic              clk_i,
    input wire logic              rstn_i,
    input wire logic              issue_valid_i,
    input wire logic              issue_ready_o,
    input wire exec_op_type       issue_op_i,
    input wire logic [DATA_W-1:0] issue_imm_i,
    input wire logic [PC_W-1:0]   issue_pc_i,
    input wire logic [DATA_W-1:0] mem_rdata_i,
    input wire logic [PC_W-1:0]   stack_top_i,
    input wire logic              mem_we_o,
    input wire logic [DATA_W-1:0] mem_wdata_o,
    input wire logic              stack_pop_o,
    input wire logic              pc_load_o,
    input wire logic [PC_W-1:0]   pc_o,
    input wire logic              discard_o,
    input wire logic              done_o,
    input wire logic [DATA_W-1:0] acc_o
);
    logic go;
    logic pop;

    // Accepted instruction and the forms that pop the stack
    assign go  = issue_valid_i && issue_ready_o;
    assign pop = issue_op_i inside {OP_SUBROUTINE_EXIT,
        OP_RETURN_WITH_VALUE, OP_INTERRUPT_EXIT};

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    AST_POP: assert property (
        go && pop |-> stack_pop_o && !mem_we_o) else $error("no pop");
    AST_PC_POP: assert property (
        go && pop |=> pc_load_o && pc_o == $past(stack_top_i))
        else $error("pc not from stack");
    AST_IDLE_PC: assert property (
        go && issue_op_i == OP_NO_OPERATION |-> !mem_we_o ##1
        pc_load_o && pc_o == PC_W'($past(issue_pc_i) + 1'b1))
        else $error("idle pc wrong");
    AST_EXIT_TWO: assert property (
        go && issue_op_i == OP_SUBROUTINE_EXIT |=> !issue_ready_o
        && !done_o ##1 done_o && issue_ready_o) else $error("exit timing");
    AST_INC_SKIP: assert property (
        go && issue_op_i == OP_INCREMENT_SKIP_ZERO && mem_rdata_i == 8'hff
        |-> mem_we_o && mem_wdata_o == 8'h00 ##1 discard_o
        && !issue_ready_o ##1 done_o) else $error("skip timing");
    AST_DEC_RUN: assert property (
        go && issue_op_i == OP_DECREMENT_SKIP_ZERO && mem_rdata_i != 8'h01
        |=> !discard_o && done_o) else $error("false skip");
    AST_BYTE_SET: assert property (
        go && issue_op_i == OP_BYTE_SET |-> mem_we_o && mem_wdata_o == 8'hff)
        else $error("byte set wrong");
    AST_STORE: assert property (
        go && issue_op_i == OP_COPY_WORK_TO_MEM
        |-> mem_we_o && mem_wdata_o == acc_o) else $error("store wrong");
    AST_IMM: assert property (
        go && issue_op_i == OP_COPY_IMM_TO_WORK
        |=> acc_o == $past(issue_imm_i)) else $error("imm load wrong");
    AST_ROT_LEFT: assert property (
        go && issue_op_i == OP_ROTATE_LEFT |-> mem_we_o && mem_wdata_o
        == {mem_rdata_i[DATA_W-2:0], mem_rdata_i[DATA_W-1]})
        else $error("rotate wrong");
endmodule : mcu_instruction_execute_props

bind mcu_instruction_execute mcu_instruction_execute_props #(
    .DATA_W(DATA_W), .PC_W(PC_W), .ADDR_W(ADDR_W)) i_props (
    .clk_i(clk_i), .rstn_i(rstn_i), .issue_valid_i(issue_valid_i),
    .issue_ready_o(issue_ready_o), .issue_op_i(issue_op_i),
    .issue_imm_i(issue_imm_i), .issue_pc_i(issue_pc_i),
    .mem_rdata_i(mem_rdata_i), .stack_top_i(stack_top_i),
    .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o),
    .stack_pop_o(stack_pop_o), .pc_load_o(pc_load_o), .pc_o(pc_o),
    .discard_o(discard_o), .done_o(done_o), .acc_o(acc_o));
`default_nettype wire

// File: mcu_instruction_execute_tb_top.sv
`default_nettype none
module mcu_instruction_execute_tb_top
    import mcu_exec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        valid = 1'b0;
    exec_op_type op = OP_NO_OPERATION;
    logic [6:0]  addr = 7'h00;
    logic [7:0]  imm = 8'h00;
    logic [2:0]  bitn = 3'h0;
    logic [10:0] pc = 11'h000;
    logic [7:0]  rdata = 8'h00;
    logic [10:0] stk = 11'h000;
    logic        ready, we, pop, pcl, disc, done, car, gie;
    logic [6:0]  maddr;
    logic [7:0]  wdata, acc, acc_e;
    logic [10:0] pco;
    logic        car_e, gie_e;
    int          n_fail, checked, cyc, seed;

    mcu_instruction_execute i_mcu_instruction_execute (
        .clk_i(clk), .rstn_i(rstn), .issue_valid_i(valid),
        .issue_ready_o(ready), .issue_op_i(op), .issue_addr_i(addr),
        .issue_imm_i(imm), .issue_bit_i(bitn), .issue_pc_i(pc),
        .mem_rdata_i(rdata), .stack_top_i(stk), .mem_we_o(we),
        .mem_addr_o(maddr), .mem_wdata_o(wdata), .stack_pop_o(pop),
        .pc_load_o(pcl), .pc_o(pco), .discard_o(disc), .done_o(done),
        .acc_o(acc), .carry_o(car), .global_interrupt_enable_o(gie));

    // Free running clock
    always #12.5 clk = ~clk;

    task automatic wrap_up();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    // Hang guard, well above the expected run of about 1050 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc > 5000) begin
            n_fail++;
            wrap_up();
        end
    end

    task automatic chk(input logic ok, input string msg);
        checked++;
        if (!ok) begin
            n_fail++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : chk

    // Reference effect of one instruction on the expected state
    function automatic void calc(input exec_op_type o, input logic [7:0] m,
        output logic w, output logic [7:0] r, output logic s);
        r = 8'h00;
        w = o inside {OP_COPY_WORK_TO_MEM, OP_OR_INTO_MEMORY, OP_ROTATE_LEFT,
            OP_ROTATE_LEFT_VIA_CARRY, OP_ROTATE_RIGHT, OP_BYTE_SET,
            OP_ROTATE_RIGHT_VIA_CARRY, OP_SUBTRACT_BORROW_TO_MEM, OP_BIT_SET,
            OP_DECREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO};
        s = (o inside {OP_DECREMENT_SKIP_ZERO, OP_DECREMENT_TO_WORK_SKIP_ZERO}
            && m == 8'h01) || (o == OP_INCREMENT_SKIP_ZERO && m == 8'hff);
        case (o)
            OP_COPY_MEM_TO_WORK: acc_e = m;
            OP_COPY_IMM_TO_WORK: acc_e = imm;
            OP_COPY_WORK_TO_MEM: r = acc_e;
            OP_OR_MEM: acc_e = acc_e | m;
            OP_OR_IMM: acc_e = acc_e | imm;
            OP_OR_INTO_MEMORY: r = acc_e | m;
            OP_RETURN_WITH_VALUE: acc_e = imm;
            OP_INTERRUPT_EXIT: gie_e = 1'b1;
            OP_ROTATE_LEFT: r = {m[6:0], m[7]};
            OP_ROTATE_LEFT_TO_WORK: acc_e = {m[6:0], m[7]};
            OP_ROTATE_LEFT_VIA_CARRY: {car_e, r} = {m, car_e};
            OP_ROTATE_LEFT_VIA_CARRY_TO_WORK: {car_e, acc_e} = {m, car_e};
            OP_ROTATE_RIGHT: r = {m[0], m[7:1]};
            OP_ROTATE_RIGHT_TO_WORK: acc_e = {m[0], m[7:1]};
            OP_ROTATE_RIGHT_VIA_CARRY: {r, car_e} = {car_e, m};
            OP_ROTATE_RIGHT_VIA_CARRY_TO_WORK: {acc_e, car_e} = {car_e, m};
            OP_SUBTRACT_WITH_BORROW: acc_e = acc_e + ~m + car_e;
            OP_SUBTRACT_BORROW_TO_MEM: r = acc_e + ~m + car_e;
            OP_DECREMENT_SKIP_ZERO: r = m - 8'h01;
            OP_DECREMENT_TO_WORK_SKIP_ZERO: acc_e = m - 8'h01;
            OP_BYTE_SET: r = 8'hff;
            OP_BIT_SET: r = m | (8'h01 << bitn);
            OP_INCREMENT_SKIP_ZERO: r = m + 8'h01;
            default: ;
        endcase
    endfunction : calc

    // Issue one instruction at a falling edge; valid stays up for chaining, dropped during an extra cycle
    task automatic run(input exec_op_type o, input logic [7:0] m);
        logic       w;
        logic       s;
        logic       p;
        logic [7:0] d;
        op = o;
        rdata = m;
        imm = 8'($urandom);
        bitn = 3'($urandom);
        pc = 11'($urandom);
        stk = 11'($urandom);
        addr = 7'($urandom);
        valid = 1'b1;
        p = o inside {OP_SUBROUTINE_EXIT, OP_RETURN_WITH_VALUE,
            OP_INTERRUPT_EXIT};
        calc(o, m, w, d, s);
        #1;
        chk(we === w && pop === p, "write or pop strobe");
        if (w) chk(wdata === d && maddr === addr, "written byte");
        @(posedge clk);
        @(negedge clk);
        chk(acc === acc_e && car === car_e, "acc or carry");
        chk(gie === gie_e, "interrupt enable");
        chk(pcl === 1'b1 && pco === (p ? stk : pc + 11'h001), "pc");
        chk(disc === s, "discard");
        if (s || o == OP_SUBROUTINE_EXIT) begin
            valid = 1'b0;
            chk(ready === 1'b0 && done === 1'b0, "extra cycle");
            @(negedge clk);
        end
        chk(done === 1'b1 && ready === 1'b1, "done");
    endtask : run

    // Reset, corner cases, then random instruction sweeps
    initial begin
        seed = $urandom(22255);
        acc_e = 8'h00;
        car_e = 1'b0;
        gie_e = 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        chk(acc === 8'h00 && ready === 1'b1 && done === 1'b0, "reset");
        run(OP_INCREMENT_SKIP_ZERO, 8'hff);
        run(OP_DECREMENT_SKIP_ZERO, 8'h01);
        run(OP_DECREMENT_SKIP_ZERO, 8'h00);
        run(OP_DECREMENT_TO_WORK_SKIP_ZERO, 8'h01);
        run(OP_SUBROUTINE_EXIT, 8'h5a);
        for (int k = 0; k < 1000; k++) begin
            run(exec_op_type'(k % 25), 8'($urandom));
        end
        valid = 1'b0;
        wrap_up();
    end
endmodule : mcu_instruction_execute_tb_top
`default_nettype wire
